// File: bench/i2cs_master_model.sv
`default_nettype none

// behavioural bus master: it only pulls lines low, the bench supplies the pull-ups
module i2cs_master_model (
  input  wire logic scl,
  input  wire logic sda,
  output var logic  scl_oe,
  output var logic  sda_oe,
  output var logic  hung
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    hung   = 1'b0;
  end

  // release scl and wait while a slave still stretches it; bounded so a stuck hold ends the run
  task automatic rise();
    int n;
    scl_oe = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 5000) begin
      #20;
      n++;
    end
    if (n == 5000) hung = 1'b1;
    #80;  // own high time, then this master pulls low first
  endtask

  // one bit: data changes only while scl is low, sampled at the end of high time
  task automatic bit_io(input logic b, output logic s);
    sda_oe = ~b;
    #40;
    rise();
    s = sda;
    scl_oe = 1'b1;
    #40;
  endtask

  // start and repeated start both begin from a released data line
  task automatic start();
    sda_oe = 1'b0;
    #40;
    rise();
    sda_oe = 1'b1;
    #80;
    scl_oe = 1'b1;
    #40;
  endtask

  task automatic stop();
    sda_oe = 1'b1;
    #40;
    rise();
    sda_oe = 1'b0;
    #80;
  endtask

  // msb first, ninth slot released so the slave can answer
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, ack);
  endtask

  task automatic rbyte(output logic [7:0] b, input logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(nak, s);
  endtask
endmodule

`default_nettype wire

// File: bench/i2cs_slave_port_tb_top.sv
`default_nettype none

module i2cs_slave_port_tb_top import i2cs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic         core_clk;
  logic         rst;
  logic         buf_rd;
  logic         int_clr;
  i2cs_wr_t     ctrl_wr;
  i2cs_wr_t     addr_wr;
  i2cs_wr_t     buf_wr;
  logic         m_scl_oe;
  logic         m_sda_oe;
  logic         m_hung;
  logic [7:0]   port_control_reg;
  logic [7:0]   rx_tx_buffer;
  logic [7:0]   own_address_reg;
  i2cs_status_t port_status_reg;
  logic         port_interrupt_flag;
  logic         scl_oe;
  logic         sda_oe;
  logic [1:0]   pin_dir;
  logic         master_tx;
  logic         arb_lost;
  int           fail_count;
  int           n_tests;
  // wired-AND bus with pull-ups: released lines read high
  wire logic    scl = ~(m_scl_oe | scl_oe);
  wire logic    sda = ~(m_sda_oe | sda_oe);

  always #10 core_clk = ~core_clk;

  i2cs_slave_port u_dut (
    .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .pin_direction_bits(pin_dir),
    .ctrl_wr(ctrl_wr), .addr_wr(addr_wr), .buf_wr(buf_wr), .buf_rd(buf_rd), .int_clr(int_clr),
    .master_tx(master_tx), .port_control_reg(port_control_reg), .port_status_reg(port_status_reg),
    .rx_tx_buffer(rx_tx_buffer), .own_address_reg(own_address_reg),
    .port_interrupt_flag(port_interrupt_flag), .arb_lost(arb_lost), .scl_out(), .scl_oe(scl_oe),
    .sda_out(), .sda_oe(sda_oe)
  );

  i2cs_master_model u_mst (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .hung(m_hung));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask

  // software strobes last one cycle, launched and dropped on falling edges
  task automatic pulse(input int k, input logic [7:0] d);
    @(negedge core_clk);
    case (k)
      0: ctrl_wr = '{1'b1, d};
      1: addr_wr = '{1'b1, d};
      2: buf_wr = '{1'b1, d};
      3: buf_rd = 1'b1;
      default: int_clr = 1'b1;
    endcase
    @(negedge core_clk);
    {ctrl_wr.wr, addr_wr.wr, buf_wr.wr, buf_rd, int_clr} = 5'h00;
  endtask

  // answer lands a few clocks after the ninth fall, past the synchronisers
  task automatic settle();
    repeat (6) @(negedge core_clk);
  endtask

  task automatic wait_hold();
    int n;
    n = 0;
    while (scl_oe !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 20) begin
      fail_count++;
      complete_run();
    end
  endtask

  task automatic send(input logic [7:0] b, input logic nak);
    logic a;
    u_mst.wbyte(b, a);
    settle();
    chk("ack", {7'h0, a}, {7'h0, nak});
  endtask

  task automatic t_reset();
    chk("control", port_control_reg, 8'h00);
    chk("status", {2'b00, port_status_reg}, 8'h00);
    chk("buffer", rx_tx_buffer, BUF_RST);
    chk("address", own_address_reg, ADDR_RST);
    chk("pin drive", {6'h0, scl_oe, sda_oe}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_write7();
    pulse(1, 8'ha0);
    pulse(0, {4'h2, MODE_SLV7});
    chk("control", port_control_reg, {4'h2, MODE_SLV7});
    u_mst.start();
    settle();
    chk("start", {7'h0, port_status_reg.start}, 8'h01);
    send(8'ha0, 1'b0);
    chk("buffer", rx_tx_buffer, 8'ha0);
    chk("status", {2'b00, port_status_reg}, 8'h11);
    chk("irq", {7'h0, port_interrupt_flag}, 8'h01);
    pulse(3, 8'h00);
    pulse(4, 8'h00);
    chk("bf irq", {6'h0, port_interrupt_flag, port_status_reg.bf}, 8'h00);
    send(8'h5c, 1'b0);
    chk("buffer", rx_tx_buffer, 8'h5c);
    chk("status", {2'b00, port_status_reg}, 8'h19);
    $display("test write done");
  endtask

  task automatic t_overflow();
    send(8'h33, 1'b1);
    chk("buffer", rx_tx_buffer, 8'h5c);
    chk("ov", {7'h0, port_control_reg[CTL_OV_BIT]}, 8'h01);
    chk("irq", {7'h0, port_interrupt_flag}, 8'h01);
    pulse(3, 8'h00);
    chk("ov bf", {6'h0, port_control_reg[CTL_OV_BIT], port_status_reg.bf}, 8'h02);
    send(8'h44, 1'b1);
    chk("buffer", rx_tx_buffer, 8'h5c);
    pulse(0, {4'h2, MODE_SLV7});
    chk("control", port_control_reg, {4'h2, MODE_SLV7});
    u_mst.stop();
    settle();
    chk("stop", {7'h0, port_status_reg.stop}, 8'h01);
    $display("test overflow done");
  endtask

  task automatic t_read();
    logic [7:0] d;
    pulse(4, 8'h00);
    u_mst.start();
    send(8'ha1, 1'b0);
    wait_hold();
    chk("rw", {7'h0, port_status_reg.rw}, 8'h01);
    pulse(2, 8'h96);
    pulse(0, {4'h3, MODE_SLV7});
    u_mst.rbyte(d, 1'b1);
    chk("read data", d, 8'h96);
    u_mst.stop();
    settle();
    chk("pin drive", {6'h0, scl_oe, sda_oe}, 8'h00);
    pulse(3, 8'h00);
    $display("test read done");
  endtask

  // slave disabled, then firmware master mode: the slave must stay silent
  task automatic t_idle();
    for (int i = 0; i < 2; i++) begin
      pulse(0, (i == 0) ? {4'h0, MODE_SLV7} : {4'h2, MODE_FW_MST});
      u_mst.start();
      send(8'ha0, 1'b1);
      u_mst.stop();
    end
    $display("test idle done");
  endtask

  // firmware master sends a one but the other master pulls sda low: our drive must let go
  task automatic t_arb();
    logic a;
    @(negedge core_clk);
    master_tx = 1'b1;
    u_mst.start();
    u_mst.wbyte(8'h00, a);
    settle();
    chk("arb lost", {7'h0, arb_lost}, 8'h01);
    pin_dir = 2'b00;
    settle();
    chk("master drive", {6'h0, scl_oe, sda_oe}, 8'h00);
    pin_dir = 2'b11;
    master_tx = 1'b0;
    u_mst.stop();
    settle();
    chk("arb lost", {7'h0, arb_lost}, 8'h00);
    $display("test arbitration done");
  endtask

  task automatic t_mismatch();
    pulse(0, {4'h2, MODE_SLV7_SS});
    pulse(4, 8'h00);
    u_mst.start();
    settle();
    chk("start irq", {7'h0, port_interrupt_flag}, 8'h01);
    pulse(4, 8'h00);
    send(8'hb2, 1'b1);
    chk("irq", {7'h0, port_interrupt_flag}, 8'h00);
    send(8'ha0, 1'b1);
    u_mst.stop();
    $display("test mismatch done");
  endtask

  task automatic t_ten();
    pulse(0, {4'h2, MODE_SLV10_SS});
    pulse(1, {TEN_HDR, 2'b01, 1'b0});
    u_mst.start();
    send(8'hf2, 1'b0);
    wait_hold();
    chk("ua bf", {6'h0, port_status_reg.ua, port_status_reg.bf}, 8'h03);
    pulse(1, 8'h34);
    settle();
    chk("ua hold", {6'h0, port_status_reg.ua, scl_oe}, 8'h00);
    pulse(3, 8'h00);
    send(8'h34, 1'b0);
    wait_hold();
    chk("buffer", rx_tx_buffer, 8'h34);
    pulse(1, {TEN_HDR, 2'b01, 1'b0});
    pulse(3, 8'h00);
    send(8'h77, 1'b0);
    chk("buffer", rx_tx_buffer, 8'h77);
    u_mst.stop();
    $display("test ten bit done");
  endtask

  // a master stuck on a held clock ends the run
  always @(posedge m_hung) begin
    fail_count++;
    complete_run();
  end

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    ctrl_wr = '0;
    addr_wr = '0;
    buf_wr = '0;
    buf_rd = 1'b0;
    int_clr = 1'b0;
    pin_dir = 2'b11;
    master_tx = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_write7();
    t_overflow();
    t_read();
    t_idle();
    t_arb();
    t_mismatch();
    t_ten();
    complete_run();
  end
endmodule

`default_nettype wire

// File: core/i2cs_pkg.sv
`default_nettype none

package i2cs_pkg;

  // control register field positions
  localparam int CTL_OV_BIT   = 6;
  localparam int CTL_EN_BIT   = 5;
  localparam int CTL_CKP_BIT  = 4;
  localparam int CTL_MODE_MSB = 3;

  // mode field encodings
  localparam logic [3:0] MODE_SLV7     = 4'h6;
  localparam logic [3:0] MODE_SLV10    = 4'h7;
  localparam logic [3:0] MODE_FW_MST   = 4'hb;
  localparam logic [3:0] MODE_SLV7_SS  = 4'he;
  localparam logic [3:0] MODE_SLV10_SS = 4'hf;

  // values after reset
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] BUF_RST  = 8'h00;

  // bit counts and address patterns
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] BYTE_LAST   = 4'h7;
  localparam logic [3:0] BYTE_END    = 4'h9;
  localparam logic [4:0] TEN_HDR     = 5'h1e;
  localparam int         TEN_HDR_LSB = 3;

  // slave sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RX    = 5'b00010,
    ST_ACK   = 5'b00100,
    ST_TX    = 5'b01000,
    ST_TXACK = 5'b10000
  } i2cs_state_t;

  // read-only status word
  typedef struct packed {
    logic stop;
    logic start;
    logic data_na;
    logic rw;
    logic ua;
    logic bf;
  } i2cs_status_t;

  // software write strobes with data
  typedef struct packed {
    logic       wr;
    logic [7:0] data;
  } i2cs_wr_t;

endpackage

`default_nettype wire

// File: core/i2cs_slave_port.sv
// Contract
// R1: a master sending high that sees low on SDA while SCL high stops driving SDA
// R2: a master that lost arbitration may clock only to the end of that byte; the code cuts its SCL drive on the ninth SCL fall counted from the loss
// R3: a master-slave that lost arbitration is at once a slave receiver; the sequencer runs only in slave modes, held idle in MODE_FW_MST
// R4: each party holds SCL low until its own low time ends; longest wins
// R5: after SCL rises, the first party done with its high time pulls SCL low
// R6: all slave behaviour but general call, 7-bit and 10-bit addressing
// R7: the port works only while the enable bit (control bit 5) is set
// R8: mode field bits 3..0 picks 7/10-bit slave, either with start/stop irq, or master
// R9: enabled in an I2C mode, pins set as inputs become open-drain
// R10: status is read-only: start, stop, data/address, update-address, direction
// R11: reception is double-buffered; a whole byte moves to the buffer and raises the flag
// R12: a second byte before the buffer is read sets overflow and is dropped
// R13: software loads the 10-bit high pattern first, then the low address byte
// R14: as slave transmitter the port overrides the input pins with its data
// R15: on match or matched data the port acknowledges and copies the shift register
// R16: buffer full or overflow set: no copy, no acknowledge, flag still set
// R17: reading the buffer clears buffer full; only software clears overflow
// R18: after enable wait for start, then shift eight bits on SCL rising edges
// R19: on the eighth falling edge compare shift bits 7..1 with the own address
// R20: on clean match load buffer, set full, acknowledge; flag at ninth falling edge
// R21: 10-bit address bytes set flag, full, update-address and hold SCL until rewrite
// R22: a matched write address clears the direction bit and fills the buffer
// R23: start is SDA falling with SCL high, stop is SDA rising with SCL high
// R24: software loads the transmit byte, then sets the release bit to free SCL
// R25: SCL and SDA are synchronised before any edge detection
`default_nettype none

module i2cs_slave_port
  import i2cs_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  input  wire logic [1:0]   pin_direction_bits,
  input  wire i2cs_wr_t     ctrl_wr,
  input  wire i2cs_wr_t     addr_wr,
  input  wire i2cs_wr_t     buf_wr,
  input  wire logic         buf_rd,
  input  wire logic         int_clr,
  input  wire logic         master_tx,
  output logic [7:0]        port_control_reg,
  output i2cs_status_t      port_status_reg,
  output logic [7:0]        rx_tx_buffer,
  output logic [7:0]        own_address_reg,
  output logic              port_interrupt_flag,
  output logic              arb_lost,
  output logic              scl_out,
  output logic              scl_oe,
  output logic              sda_out,
  output logic              sda_oe
);

  // mode decoding shared by the sequencer and the pin drivers
  function automatic logic mode_is_slave(input logic [3:0] m);
    mode_is_slave = (m == MODE_SLV7) || (m == MODE_SLV10) || (m == MODE_SLV7_SS) || (m == MODE_SLV10_SS);
  endfunction

  function automatic logic mode_is_ten(input logic [3:0] m);
    mode_is_ten = (m == MODE_SLV10) || (m == MODE_SLV10_SS);
  endfunction

  function automatic logic mode_ss_irq(input logic [3:0] m);
    mode_ss_irq = (m == MODE_SLV7_SS) || (m == MODE_SLV10_SS) || (m == MODE_FW_MST);
  endfunction

  logic        scl_s1, scl_s2, scl_p;
  logic        sda_s1, sda_s2, sda_p;
  logic        en_q, ckp_q, ov_q;
  logic [3:0]  mode_q;
  i2cs_state_t state_q;
  logic [3:0]  bitcnt_q;
  logic [7:0]  sr_q, buf_q, addr_q;
  logic        bf_q, ua_q, rw_q, dna_q, start_q, stop_q, irq_q;
  logic        addr_phase_q, ten_hi_ok_q, ten_full_q, tx_q, ack_q, hold_q;
  logic        arb_q, mkill_q;
  logic [3:0]  mfall_q;
  logic        sda_oe_q, scl_oe_q;

  // two flops per pin before use, a third stage for edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_p  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_p  <= 1'b1;
    end else begin
      scl_s1 <= scl_in;  // see R25
      scl_s2 <= scl_s1;
      scl_p  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_p  <= sda_s2;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det, slave_on, i2c_on, is_ten;
  assign scl_rise  = scl_s2 & ~scl_p;
  assign scl_fall  = ~scl_s2 & scl_p;
  assign start_det = scl_s2 & scl_p & sda_p & ~sda_s2;  // see R23
  assign stop_det  = scl_s2 & scl_p & ~sda_p & sda_s2;  // see R23
  assign i2c_on    = en_q & (mode_is_slave(mode_q) | (mode_q == MODE_FW_MST));  // see R7
  assign slave_on  = en_q & mode_is_slave(mode_q);  // see R8
  assign is_ten    = mode_is_ten(mode_q);

  // address match and byte-end decisions
  logic byte_done, seven_hit, ten_hi, ten_lo, hit, blocked, accept, go_tx, need_ua, ovf_evt;
  assign byte_done = (state_q == ST_RX) & scl_fall & (bitcnt_q == BYTE_BITS);  // see R19
  assign seven_hit = sr_q[7:1] == addr_q[7:1];  // see R19
  assign ten_hi    = is_ten & ~ten_hi_ok_q & (sr_q[7:TEN_HDR_LSB] == TEN_HDR) & seven_hit
                     & (~sr_q[0] | ten_full_q);
  assign ten_lo    = is_ten & ten_hi_ok_q & (sr_q == addr_q);
  assign hit       = ~addr_phase_q | (is_ten ? (ten_hi | ten_lo) : seven_hit);  // see R6
  assign blocked   = bf_q | ov_q;
  assign accept    = byte_done & hit & ~blocked;  // see R16
  assign go_tx     = addr_phase_q & sr_q[0] & (~is_ten | ten_hi);
  assign need_ua   = addr_phase_q & is_ten & ~go_tx;
  assign ovf_evt   = byte_done & hit & bf_q;  // see R12

  logic tx_hold_evt, byte_irq_evt, ss_irq_evt;
  assign tx_hold_evt  = scl_fall & (((state_q == ST_ACK) & tx_q) | (state_q == ST_TXACK));
  assign byte_irq_evt = scl_fall & ((state_q == ST_ACK) | (state_q == ST_TXACK));  // see R20
  assign ss_irq_evt   = i2c_on & mode_ss_irq(mode_q) & (start_det | stop_det);

  // control word; hardware sets of overflow beat a software write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_q   <= 1'b0;
      ckp_q  <= 1'b0;
      ov_q   <= 1'b0;
      mode_q <= MODE_RST;
    end else begin
      if (ctrl_wr.wr) begin
        en_q   <= ctrl_wr.data[CTL_EN_BIT];
        mode_q <= ctrl_wr.data[CTL_MODE_MSB:0];
      end
      if (tx_hold_evt & slave_on)
        ckp_q <= 1'b0;
      else if (ctrl_wr.wr)
        ckp_q <= ctrl_wr.data[CTL_CKP_BIT];
      ov_q <= (ovf_evt & slave_on) | (ctrl_wr.wr ? ctrl_wr.data[CTL_OV_BIT] : ov_q);  // see R17
    end
  end

  // slave sequencer: shift, compare, acknowledge, transmit
  always_ff @(posedge core_clk) begin
    if (rst || !slave_on) begin
      state_q      <= ST_IDLE;  // see R7
      bitcnt_q     <= 4'h0;
      sr_q         <= 8'h00;
      addr_phase_q <= 1'b0;
      ten_hi_ok_q  <= 1'b0;
      ten_full_q   <= 1'b0;
      tx_q         <= 1'b0;
      ack_q        <= 1'b0;
      hold_q       <= 1'b0;
      rw_q         <= 1'b0;
      dna_q        <= 1'b0;
    end else if (start_det) begin
      state_q      <= ST_RX;  // see R18
      bitcnt_q     <= 4'h0;
      addr_phase_q <= 1'b1;
      ten_hi_ok_q  <= 1'b0;
      tx_q         <= 1'b0;
      ack_q        <= 1'b0;
      hold_q       <= 1'b0;
    end else if (stop_det) begin
      state_q     <= ST_IDLE;
      ten_hi_ok_q <= 1'b0;
      ten_full_q  <= 1'b0;
      tx_q        <= 1'b0;
      ack_q       <= 1'b0;
      hold_q      <= 1'b0;
    end else begin
      // software releases a held clock; a new hold below takes precedence
      if (addr_wr.wr && !tx_q)
        hold_q <= 1'b0;  // see R21
      if (ctrl_wr.wr && ctrl_wr.data[CTL_CKP_BIT] && tx_q)
        hold_q <= 1'b0;  // see R24
      case (state_q)
        ST_RX: begin
          if (scl_rise && bitcnt_q < BYTE_BITS) begin
            sr_q     <= {sr_q[6:0], sda_s2};  // see R18
            bitcnt_q <= bitcnt_q + 4'h1;
          end
          if (byte_done) begin
            if (hit) begin
              state_q <= ST_ACK;
              ack_q   <= ~blocked;  // see R15
              dna_q   <= ~addr_phase_q;
              if (addr_phase_q && (!is_ten || ten_hi))
                rw_q <= sr_q[0];  // see R22
              if (addr_phase_q) begin
                addr_phase_q <= ten_hi & ~sr_q[0];
                ten_hi_ok_q  <= ten_hi & ~sr_q[0];
                tx_q         <= go_tx;
              end
              if (ten_lo)
                ten_full_q <= 1'b1;
            end else begin
              state_q <= ST_IDLE;  // not addressed: wait for the next start
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            ack_q    <= 1'b0;
            bitcnt_q <= 4'h0;
            if (tx_q) begin
              state_q <= ST_TX;
              hold_q  <= 1'b1;  // stretch until data is loaded and the release bit is set
            end else begin
              state_q <= ST_RX;
              hold_q  <= ua_q;  // see R21
            end
          end
        end
        ST_TX: begin
          if (buf_wr.wr && hold_q)
            sr_q <= buf_wr.data;
          else if (scl_fall && !hold_q) begin
            sr_q     <= {sr_q[6:0], 1'b1};
            bitcnt_q <= bitcnt_q + 4'h1;
            if (bitcnt_q == BYTE_LAST)
              state_q <= ST_TXACK;
          end
        end
        ST_TXACK: begin
          if (scl_rise && sda_s2) begin
            state_q <= ST_IDLE;  // master did not acknowledge: transfer over
            tx_q    <= 1'b0;
            rw_q    <= 1'b0;
          end else if (scl_fall) begin
            state_q  <= ST_TX;
            bitcnt_q <= 4'h0;
            hold_q   <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // buffer and flags; each hardware set wins over a same-cycle software clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      buf_q   <= BUF_RST;
      addr_q  <= ADDR_RST;
      bf_q    <= 1'b0;
      ua_q    <= 1'b0;
      irq_q   <= 1'b0;
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end else begin
      if (addr_wr.wr)
        addr_q <= addr_wr.data;  // see R13
      if (accept && slave_on)
        buf_q <= sr_q;  // see R11
      else if (buf_wr.wr)
        buf_q <= buf_wr.data;
      bf_q  <= (slave_on & accept) | buf_wr.wr | (bf_q & ~buf_rd);  // see R17
      ua_q  <= (slave_on & accept & need_ua) | (ua_q & ~addr_wr.wr);  // see R21
      irq_q <= (slave_on & byte_irq_evt) | ss_irq_evt | (irq_q & ~int_clr);  // see R16
      if (!en_q) begin
        start_q <= 1'b0;
        stop_q  <= 1'b0;
      end else if (start_det) begin
        start_q <= 1'b1;  // see R10
        stop_q  <= 1'b0;
      end else if (stop_det) begin
        start_q <= 1'b0;
        stop_q  <= 1'b1;
      end
    end
  end

  // arbitration watch for firmware master transmit; slave side runs on regardless
  always_ff @(posedge core_clk) begin
    if (rst || !master_tx || !i2c_on || start_det || stop_det) begin
      arb_q   <= 1'b0;
      mfall_q <= 4'h0;
      mkill_q <= 1'b0;
    end else begin
      if (!arb_q && scl_rise && pin_direction_bits[1] && !sda_s2)
        arb_q <= 1'b1;  // see R1
      if (arb_q && scl_fall && !mkill_q) begin
        mfall_q <= mfall_q + 4'h1;
        if (mfall_q == BYTE_LAST + 4'h1)
          mkill_q <= 1'b1;  // see R2
      end
    end
  end

  // open-drain drivers: only ever pull low, never drive high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= (slave_on & (ack_q | ((state_q == ST_TX) & ~sr_q[7] & (bitcnt_q < BYTE_BITS))))  // see R14
                  | (i2c_on & ~pin_direction_bits[1] & ~arb_q);  // see R9
      scl_oe_q <= (slave_on & hold_q)  // see R4
                  | (i2c_on & ~pin_direction_bits[0] & ~mkill_q);  // see R5
    end
  end

  // lost arbitration only cuts our drive; the slave sequencer keeps listening in slave modes, held idle in MODE_FW_MST
  assign arb_lost            = arb_q;  // see R3
  assign sda_oe              = sda_oe_q;
  assign scl_oe              = scl_oe_q;
  assign sda_out             = 1'b0;
  assign scl_out             = 1'b0;
  assign port_control_reg    = {1'b0, ov_q, en_q, ckp_q, mode_q};
  assign port_status_reg     = '{stop: stop_q, start: start_q, data_na: dna_q, rw: rw_q, ua: ua_q, bf: bf_q};
  assign rx_tx_buffer        = buf_q;
  assign own_address_reg     = addr_q;
  assign port_interrupt_flag = irq_q;

  property p_block_no_ack;
    @(posedge core_clk) disable iff (rst) (byte_done && hit && blocked && slave_on) |=> !ack_q;
  endproperty
  a_block_no_ack: assert property (p_block_no_ack) else $error("ack raised while buffer blocked"); // see R16

  property p_accept_loads;
    @(posedge core_clk) disable iff (rst) (accept && slave_on) |=> (bf_q && buf_q == $past(sr_q) && ack_q);
  endproperty
  a_accept_loads: assert property (p_accept_loads) else $error("accepted byte not buffered"); // see R20

  property p_overflow_set;
    @(posedge core_clk) disable iff (rst) (ovf_evt && slave_on) |=> ov_q ##1 (ov_q || $past(ctrl_wr.wr));
  endproperty
  a_overflow_set: assert property (p_overflow_set) else $error("overflow not flagged"); // see R12

  property p_read_clears_bf;
    @(posedge core_clk) disable iff (rst) (buf_rd && !accept && !buf_wr.wr) |=> !bf_q;
  endproperty
  a_read_clears_bf: assert property (p_read_clears_bf) else $error("buffer full survived read"); // see R17

  property p_disabled_idle;
    @(posedge core_clk) disable iff (rst) (!en_q) [*2] |-> (state_q == ST_IDLE && !sda_oe_q && !start_q);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("port active while disabled"); // see R7

  property p_arb_release;
    @(posedge core_clk) disable iff (rst) arb_q |=> !(sda_oe_q && !ack_q && state_q != ST_TX);
  endproperty
  a_arb_release: assert property (p_arb_release) else $error("sda still driven after arbitration loss"); // see R1

  property p_ua_holds_scl;
    @(posedge core_clk) disable iff (rst) (hold_q && slave_on && !rst) |=> scl_oe_q;
  endproperty
  a_ua_holds_scl: assert property (p_ua_holds_scl) else $error("clock not stretched while held"); // see R21

  property p_start_flag;
    @(posedge core_clk) disable iff (rst) (start_det && en_q) |=> (start_q && !stop_q);
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("start not reported"); // see R23

  property p_shift_count;
    @(posedge core_clk) disable iff (rst)
      (slave_on && state_q == ST_RX && scl_rise && bitcnt_q < BYTE_BITS && !start_det && !stop_det)
      |=> bitcnt_q == $past(bitcnt_q) + 4'h1;
  endproperty
  a_shift_count: assert property (p_shift_count) else $error("bit not counted on rising edge"); // see R18

  property p_mkill_after_byte;
    @(posedge core_clk) disable iff (rst) mkill_q |-> (arb_q && mfall_q == BYTE_END);
  endproperty
  a_mkill_after_byte: assert property (p_mkill_after_byte) else $error("master clock cut at wrong time"); // see R2

endmodule

`default_nettype wire
